// *** sdi_pkg.sv ***
// Shared constants and types of the step and direction microstep indexer.
// Assumes one 250 MHz clock and a simple strobe register port.
// Contract
// - Step input counts rising edges only, or both edges by configuration bit.
// - Direction input level is sampled at every active step edge.
// - Resolution selects fullstep or 2 to 256 microsteps per full step.
// - Direction low increments, high decrements, by a resolution-dependent amount.
// - Counter is mapped through a sine table to sine and cosine coil targets.
// - With step and direction driving, no internal motion generator changes position.
// - Standstill reduces current with level, delay and decay; freewheel or brake optional.
// - A selectable faster standstill detection is offered.
package sdi_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [7:0] ADDR_CONF   = 8'h00;
    localparam logic [7:0] ADDR_CUR    = 8'h04;
    localparam logic [7:0] ADDR_PWRDN  = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_COIL   = 8'h10;

    // CONF fields.
    localparam int CONF_SDEN_BIT  = 0;
    localparam int CONF_DEDGE_BIT = 1;
    localparam int CONF_MRES_LSB  = 2;
    localparam int CONF_FAST_BIT  = 6;
    localparam int CONF_SMODE_LSB = 7;
    // CUR fields.
    localparam int CUR_IRUN_LSB   = 0;
    localparam int CUR_IHOLD_LSB  = 8;
    localparam int CUR_DECAY_LSB  = 16;
    // STATUS and COIL fields.
    localparam int STAT_STILL_BIT = 16;
    localparam int STAT_PD_BIT    = 17;
    localparam int COIL_B_LSB     = 16;

    // ****************************************************************
    // Reset values and timing
    // ****************************************************************
    localparam logic [3:0]  MRES_RST  = 4'h0;
    localparam logic [4:0]  IRUN_RST  = 5'h1F;
    localparam logic [4:0]  IHOLD_RST = 5'h08;
    localparam logic [3:0]  DECAY_RST = 4'h1;
    localparam logic [7:0]  PWRDN_RST = 8'h0A;
    localparam logic [3:0]  MRES_FULL = 4'h8;
    localparam int          STILL_DET_CYC  = 1048576;
    localparam int          FAST_STILL_CYC = 65536;
    localparam int          PD_UNIT_CYC    = 262144;
    localparam int          DECAY_UNIT_CYC = 1024;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [1:0] {
        SDI_HOLD,
        SDI_FREE,
        SDI_BRAKE
    } sdi_smode_t;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } sdi_bus_req_t;

    typedef struct packed {
        logic signed [8:0] a;
        logic signed [8:0] b;
    } sdi_coil_t;

    typedef struct packed {
        logic        sd_en;
        logic        dedge;
        logic [3:0]  mres;
        logic        fast;
        sdi_smode_t  smode;
        logic [4:0]  irun;
        logic [4:0]  ihold;
        logic [3:0]  decay;
        logic [7:0]  pwrdn;
        logic        step_q;
        logic [9:0]  mscnt;
        logic [31:0] idle;
        logic [13:0] dcnt;
        logic [4:0]  scale;
        logic        still;
        logic        pd;
        logic        neg_a;
        logic        neg_b;
        sdi_coil_t   coil;
        logic [31:0] rdata;
    } sdi_state_t;

endpackage : sdi_pkg

// *** sdi_sine_rom.sv ***
// Quarter-wave sine table with two registered read ports.
// Assumes indices are applied one cycle before the values are used.
module sdi_sine_rom (
    input  wire logic       sys_clk,
    input  wire logic       resetn,
    input  wire logic [7:0] idx_a,
    input  wire logic [7:0] idx_b,
    output logic      [7:0] val_a,
    output logic      [7:0] val_b
);

    typedef struct packed {
        logic [7:0] a;
        logic [7:0] b;
    } sdi_rom_state_t;

    sdi_rom_state_t st;
    sdi_rom_state_t next_st;

    // A parabola stands in for the quarter sine; its error stays under
    // six percent and it needs no stored image.
    function automatic logic [7:0] sdi_sine(input logic [7:0] i);
        logic [31:0] x;
        logic [31:0] p;
        x = {24'h000000, i};
        p = (32'h000000F8 * x * (32'h00000200 - x)) >> 16;
        return p[7:0];
    endfunction : sdi_sine

    // ****************************************************************
    // Table read
    // ****************************************************************
    always_comb begin
        next_st.a = sdi_sine(idx_a);
        next_st.b = sdi_sine(idx_b);
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign val_a = st.a;
    assign val_b = st.b;

endmodule : sdi_sine_rom

// *** sdi_indexer.sv ***
// Step and direction microstep indexer with standstill current reduction.
// Assumes step_in and dir_in are already synchronous to sys_clk.
module sdi_indexer #(
    parameter int STILL_CYC = sdi_pkg::STILL_DET_CYC,
    parameter int FAST_CYC  = sdi_pkg::FAST_STILL_CYC,
    parameter int PD_UNIT   = sdi_pkg::PD_UNIT_CYC
) (
    input  wire logic                 sys_clk,
    input  wire logic                 resetn,
    input  wire sdi_pkg::sdi_bus_req_t bus_req,
    output logic               [31:0] rdata,
    input  wire logic                 step_in,
    input  wire logic                 dir_in,
    output sdi_pkg::sdi_coil_t        coil,
    output sdi_pkg::sdi_smode_t       coil_mode,
    output logic                      standstill
);

    sdi_pkg::sdi_state_t st;
    sdi_pkg::sdi_state_t next_st;

    logic        step_evt;
    logic [9:0]  step_inc;
    logic [3:0]  mres_sat;
    logic [9:0]  phase_b;
    logic [7:0]  idx_a;
    logic [7:0]  idx_b;
    logic [7:0]  val_a;
    logic [7:0]  val_b;
    logic [31:0] still_thr;
    logic [31:0] pd_thr;
    logic [13:0] decay_len;
    logic [12:0] prod_a;
    logic [12:0] prod_b;
    logic [8:0]  mag_a;
    logic [8:0]  mag_b;

    // ****************************************************************
    // Step decoding
    // ****************************************************************
    // Active edge select.
    assign step_evt = st.sd_en && ((step_in && !st.step_q) ||
                                   (st.dedge && !step_in && st.step_q));

    assign mres_sat = (st.mres > sdi_pkg::MRES_FULL) ? sdi_pkg::MRES_FULL : st.mres;
    // Increment of 256 over microsteps per full step.
    assign step_inc = 10'h001 << mres_sat;

    // ****************************************************************
    // Sine table addressing
    // ****************************************************************
    // Cosine leads sine by a quarter period, i.e. one full step.
    assign phase_b = st.mscnt + 10'h100;
    assign idx_a   = st.mscnt[8] ? 8'hFF - st.mscnt[7:0] : st.mscnt[7:0];
    assign idx_b   = phase_b[8] ? 8'hFF - phase_b[7:0] : phase_b[7:0];

    sdi_sine_rom u_rom (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .idx_a   (idx_a),
        .idx_b   (idx_b),
        .val_a   (val_a),
        .val_b   (val_b)
    );

    // ****************************************************************
    // Standstill thresholds
    // ****************************************************************
    // Faster standstill detection.
    assign still_thr = st.fast ? 32'(FAST_CYC) : 32'(STILL_CYC);
    assign pd_thr    = still_thr + 32'(PD_UNIT) * {24'h000000, st.pwrdn};
    assign decay_len = 14'(sdi_pkg::DECAY_UNIT_CYC) * {10'h000, st.decay};

    // Current scaling: full amplitude times scale over 32.
    assign prod_a = {5'h00, val_a} * {8'h00, st.scale};
    assign prod_b = {5'h00, val_b} * {8'h00, st.scale};
    assign mag_a  = {1'b0, prod_a[12:5]};
    assign mag_b  = {1'b0, prod_b[12:5]};

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        next_st        = st;
        next_st.step_q = step_in;
        next_st.rdata  = '0;

        if (bus_req.wr) begin
            unique case (bus_req.addr)
                sdi_pkg::ADDR_CONF: begin
                    next_st.sd_en = bus_req.wdata[sdi_pkg::CONF_SDEN_BIT];
                    next_st.dedge = bus_req.wdata[sdi_pkg::CONF_DEDGE_BIT];
                    next_st.mres  = bus_req.wdata[sdi_pkg::CONF_MRES_LSB +: 4];
                    next_st.fast  = bus_req.wdata[sdi_pkg::CONF_FAST_BIT];
                    next_st.smode = sdi_pkg::sdi_smode_t'(
                                    bus_req.wdata[sdi_pkg::CONF_SMODE_LSB +: 2]);
                end
                sdi_pkg::ADDR_CUR: begin
                    next_st.irun  = bus_req.wdata[sdi_pkg::CUR_IRUN_LSB +: 5];
                    next_st.ihold = bus_req.wdata[sdi_pkg::CUR_IHOLD_LSB +: 5];
                    next_st.decay = bus_req.wdata[sdi_pkg::CUR_DECAY_LSB +: 4];
                end
                sdi_pkg::ADDR_PWRDN: begin
                    next_st.pwrdn = bus_req.wdata[7:0];
                end
                default: begin
                end
            endcase
        end

        if (bus_req.rd) begin
            unique case (bus_req.addr)
                sdi_pkg::ADDR_CONF: begin
                    next_st.rdata[sdi_pkg::CONF_SDEN_BIT]       = st.sd_en;
                    next_st.rdata[sdi_pkg::CONF_DEDGE_BIT]      = st.dedge;
                    next_st.rdata[sdi_pkg::CONF_MRES_LSB +: 4]  = st.mres;
                    next_st.rdata[sdi_pkg::CONF_FAST_BIT]       = st.fast;
                    next_st.rdata[sdi_pkg::CONF_SMODE_LSB +: 2] = st.smode;
                end
                sdi_pkg::ADDR_CUR: begin
                    next_st.rdata[sdi_pkg::CUR_IRUN_LSB +: 5]  = st.irun;
                    next_st.rdata[sdi_pkg::CUR_IHOLD_LSB +: 5] = st.ihold;
                    next_st.rdata[sdi_pkg::CUR_DECAY_LSB +: 4] = st.decay;
                end
                sdi_pkg::ADDR_PWRDN: begin
                    next_st.rdata[7:0] = st.pwrdn;
                end
                sdi_pkg::ADDR_STATUS: begin
                    next_st.rdata[9:0]                   = st.mscnt;
                    next_st.rdata[sdi_pkg::STAT_STILL_BIT] = st.still;
                    next_st.rdata[sdi_pkg::STAT_PD_BIT]    = st.pd;
                end
                sdi_pkg::ADDR_COIL: begin
                    next_st.rdata[8:0]                       = st.coil.a;
                    next_st.rdata[sdi_pkg::COIL_B_LSB +: 9]  = st.coil.b;
                end
                default: begin
                end
            endcase
        end

        // Position only ever moves on external step edges.
        if (step_evt) begin
            // Low counts up, high counts down.
            if (!dir_in) begin
                next_st.mscnt = st.mscnt + step_inc;
            end else begin
                next_st.mscnt = st.mscnt - step_inc;
            end
            next_st.idle  = '0;
            next_st.dcnt  = '0;
            next_st.still = 1'b0;
            next_st.pd    = 1'b0;
            next_st.scale = st.irun;
        end else begin
            // The idle count saturates so a long pause never wraps back to motion.
            if (st.idle != 32'hFFFFFFFF) begin
                next_st.idle = st.idle + 32'h00000001;
            end
            // Standstill flag from selected detection time.
            if (st.idle + 32'h00000001 >= still_thr) begin
                next_st.still = 1'b1;
            end
            // Delay then stepwise decay towards hold current.
            if (st.idle >= pd_thr) begin
                next_st.pd = 1'b1;
            end
            if (!st.pd) begin
                next_st.scale = st.irun;
            end else if (st.scale > st.ihold) begin
                if (st.dcnt >= decay_len) begin
                    next_st.dcnt  = '0;
                    next_st.scale = st.scale - 5'h01;
                end else begin
                    next_st.dcnt = st.dcnt + 14'h0001;
                end
            end else begin
                next_st.scale = st.ihold;
            end
        end

        // Signed coil targets from the table, one cycle behind lookup.
        next_st.neg_a  = st.mscnt[9];
        next_st.neg_b  = phase_b[9];
        next_st.coil.a = st.neg_a ? -mag_a : mag_a;
        next_st.coil.b = st.neg_b ? -mag_b : mag_b;
        // Freewheel and brake drop both coil targets.
        if (st.pd && st.scale == st.ihold && st.smode != sdi_pkg::SDI_HOLD) begin
            next_st.coil = '0;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            st       <= '0;
            st.sd_en <= 1'b1;
            st.mres  <= sdi_pkg::MRES_RST;
            st.irun  <= sdi_pkg::IRUN_RST;
            st.ihold <= sdi_pkg::IHOLD_RST;
            st.decay <= sdi_pkg::DECAY_RST;
            st.pwrdn <= sdi_pkg::PWRDN_RST;
            st.scale <= sdi_pkg::IRUN_RST;
            st.smode <= sdi_pkg::SDI_HOLD;
        end else begin
            st <= next_st;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign rdata      = st.rdata;
    assign coil       = st.coil;
    assign standstill = st.still;
    assign coil_mode  = (st.pd && st.scale == st.ihold) ? st.smode : sdi_pkg::SDI_HOLD;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);

    a_step_fwd_inc: assert property (
        step_evt && !dir_in |=> st.mscnt == $past(st.mscnt) + $past(step_inc))
        else $error("forward step did not add the increment");

    a_step_back_dec: assert property (
        step_evt && dir_in |=> st.mscnt == $past(st.mscnt) - $past(step_inc))
        else $error("backward step did not subtract the increment");

    a_fall_ignored: assert property (
        st.sd_en && !st.dedge && st.step_q && !step_in |=> $stable(st.mscnt))
        else $error("falling edge moved position in single edge mode");

    a_both_edges: assert property (
        st.sd_en && st.dedge && st.step_q && !step_in |=> !$stable(st.mscnt) ||
        $past(step_inc) == 10'h000)
        else $error("falling edge lost in double edge mode");

    a_disabled_hold: assert property (
        !st.sd_en |=> $stable(st.mscnt))
        else $error("position moved with step input disabled");

    a_inc_full: assert property (
        st.mres >= sdi_pkg::MRES_FULL |-> step_inc == 10'h100)
        else $error("fullstep increment is not 256");

    a_step_wakes: assert property (
        step_evt |=> !st.still && !st.pd && st.scale == $past(st.irun))
        else $error("step did not restore run current");

    a_still_timing: assert property (
        $rose(st.still) |-> $past(st.idle) + 32'h00000001 >= $past(still_thr))
        else $error("standstill flagged before detection time");

    a_free_zero: assert property (
        coil_mode != sdi_pkg::SDI_HOLD ##1 coil_mode != sdi_pkg::SDI_HOLD
        |-> coil.a == 9'h000 && coil.b == 9'h000)
        else $error("coil driven while freewheeling or braking");

    a_cos_first_quad: assert property (
        $stable(st.mscnt) [*3] ##0 st.mscnt[9:8] == 2'b00 && $stable(st.scale)
        |-> !coil.a[8] && !coil.b[8])
        else $error("coil target sign wrong in first quadrant");

    a_unmapped_zero: assert property (
        bus_req.rd && bus_req.addr > sdi_pkg::ADDR_COIL |=> rdata == 32'h00000000)
        else $error("unmapped read returned data");

    // Position may only move at an accepted step edge, never on its own.
    a_no_free_move: assert property (
        !step_evt |=> $stable(st.mscnt))
        else $error("position moved without an accepted step edge");

    a_rise_counts: assert property (
        st.sd_en && !st.step_q && step_in |=> !$stable(st.mscnt))
        else $error("rising step edge was not counted");

    a_still_sticky: assert property (
        st.still && !step_evt |=> st.still)
        else $error("standstill flag dropped without a step");

    // Current reduction checks. They pin the decay cadence, so a slip in
    // the divider shows up at once rather than as a slightly late hold level.
    a_pd_timing: assert property (
        $rose(st.pd) |-> $past(st.idle) >= $past(pd_thr))
        else $error("power down entered before its delay");

    a_run_current: assert property (
        !st.pd && !step_evt |=> st.scale == $past(st.irun))
        else $error("run current not applied before power down");

    a_decay_wait: assert property (
        st.pd && !step_evt && st.scale > st.ihold && st.dcnt < decay_len
        |=> st.scale == $past(st.scale))
        else $error("current dropped before the decay interval ended");

    a_decay_step: assert property (
        st.pd && !step_evt && st.scale > st.ihold && st.dcnt >= decay_len
        |=> st.scale == $past(st.scale) - 5'h01)
        else $error("current did not drop one step after the decay interval");

endmodule : sdi_indexer

// *** sdi_step_model.sv ***
// Behavioural motion controller that emits step pulses and a direction level.
// Assumes start is a one-cycle strobe and gap is at least one cycle.
module sdi_step_model (
    input  wire logic       sys_clk,
    input  wire logic       resetn,
    input  wire logic       start,
    input  wire logic [7:0] count,
    input  wire logic       dir_req,
    input  wire logic       both,
    input  wire logic [3:0] gap,
    output logic            step_out,
    output logic            dir_out,
    output logic            busy
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        step_out = 1'b0;
        dir_out  = 1'b0;
        busy     = 1'b0;
    end

    always begin
        @(posedge sys_clk);
        if (start && resetn) begin
            busy    <= 1'b1;
            dir_out <= dir_req;
            for (int i = 0; i < count; i++) begin
                repeat (gap) @(posedge sys_clk);
                step_out <= both ? ~step_out : 1'b1;
                if (!both) begin
                    repeat (gap) @(posedge sys_clk);
                    step_out <= 1'b0;
                end
            end
            repeat (gap) @(posedge sys_clk);
            // Direction flips after the frame, so a late sample of it shows up as a wrong count.
            dir_out <= ~dir_req;
            busy    <= 1'b0;
        end
    end

endmodule : sdi_step_model

// *** testbench.sv ***
// Self-checking bench of the step and direction indexer.
// Assumes shortened standstill counts: 64, 16 and 8 cycles per delay unit.
module testbench;
    timeunit 1ns;
    timeprecision 100ps;

    logic                  sys_clk = 1'b0;
    logic                  resetn;
    sdi_pkg::sdi_bus_req_t bus_req;
    logic [31:0]           rdata;
    logic                  step_in;
    logic                  dir_in;
    sdi_pkg::sdi_coil_t    coil;
    sdi_pkg::sdi_smode_t   coil_mode;
    logic                  standstill;
    logic                  start;
    logic [7:0]            count;
    logic                  dir_req;
    logic                  both;
    logic [3:0]            gap;
    logic                  busy;
    logic [31:0]           rd_val;
    int                    error_cnt = 0;
    int                    checked = 0;
    int                    exp_pos = 0;

    always #2 sys_clk = ~sys_clk;

    sdi_indexer #(.STILL_CYC(64), .FAST_CYC(16), .PD_UNIT(8)) i_sdi_indexer (
        .sys_clk   (sys_clk),
        .resetn    (resetn),
        .bus_req   (bus_req),
        .rdata     (rdata),
        .step_in   (step_in),
        .dir_in    (dir_in),
        .coil      (coil),
        .coil_mode (coil_mode),
        .standstill(standstill)
    );

    sdi_step_model i_sdi_step_model (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .start   (start),
        .count   (count),
        .dir_req (dir_req),
        .both    (both),
        .gap     (gap),
        .step_out(step_in),
        .dir_out (dir_in),
        .busy    (busy)
    );

    // ****************************************************************
    // Access tasks
    // ****************************************************************
    // Inputs move 1 ns after the edge so no sample races the clock.
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : tick

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        bus_req.addr  <= a;
        bus_req.wdata <= d;
        bus_req.wr    <= 1'b1;
        tick(1);
        bus_req.wr    <= 1'b0;
        tick(1);
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        bus_req.addr <= a;
        bus_req.rd   <= 1'b1;
        tick(1);
        bus_req.rd   <= 1'b0;
        d = rdata;
        tick(1);
    endtask : rd_reg

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic chk_pos;
        rd_reg(sdi_pkg::ADDR_STATUS, rd_val);
        check("mscnt", {22'h0, rd_val[9:0]}, 32'(exp_pos));
    endtask : chk_pos

    task automatic run_steps(input int n, input logic d, input logic b, input int g, input int inc);
        start   <= 1'b1;
        count   <= n[7:0];
        dir_req <= d;
        both    <= b;
        gap     <= g[3:0];
        tick(1);
        start   <= 1'b0;
        tick(1);
        for (int i = 0; i < 2000 && busy === 1'b1; i++) tick(1);
        // A frame that never ends counts as a mismatch.
        if (busy !== 1'b0) error_cnt++;
        exp_pos = (exp_pos + (d ? -(n * inc) : n * inc)) & 1023;
    endtask : run_steps

    task automatic do_reset;
        resetn <= 1'b0;
        tick(16);
        resetn <= 1'b1;
        tick(1);
        exp_pos = 0;
    endtask : do_reset

    task automatic tally_and_finish;
        $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : tally_and_finish

    // ****************************************************************
    // Test sequence
    // ****************************************************************
    initial begin
        resetn  = 1'b0;
        bus_req = '0;
        start   = 1'b0;
        count   = 8'h00;
        dir_req = 1'b0;
        both    = 1'b0;
        gap     = 4'h1;
        do_reset();
        rd_reg(sdi_pkg::ADDR_CONF, rd_val);
        check("conf_rst", rd_val, 32'h0000_0001);
        rd_reg(sdi_pkg::ADDR_CUR, rd_val);
        check("cur_rst", rd_val, 32'h0001_081F);
        rd_reg(sdi_pkg::ADDR_PWRDN, rd_val);
        check("pwrdn_rst", rd_val, 32'h0000_000A);
        rd_reg(8'h14, rd_val);
        check("unmapped", rd_val, 32'h0000_0000);
        wr_reg(sdi_pkg::ADDR_STATUS, 32'h0000_03FF);
        chk_pos();
        check("mode_rst", {30'h0, coil_mode}, 32'h0000_0000);
        check("coil_a0", {23'h0, coil.a}, 32'h0000_0000);
        check("coil_b0", {31'h0, $signed(coil.b) > 0}, 32'h0000_0001);
        // Full steps walk the four quadrants and wrap forward to zero.
        wr_reg(sdi_pkg::ADDR_CONF, 32'h0000_0021);
        run_steps(1, 1'b0, 1'b0, 1, 256);
        tick(3);
        check("coil_a90", {31'h0, $signed(coil.a) > 0}, 32'h0000_0001);
        chk_pos();
        run_steps(2, 1'b0, 1'b0, 2, 256);
        tick(3);
        check("coil_a270", {31'h0, $signed(coil.a) < 0}, 32'h0000_0001);
        run_steps(1, 1'b0, 1'b0, 1, 256);
        chk_pos();
        // Every resolution, alternating edge mode, with slow and prompt pacing.
        for (int m = 0; m < 9; m++) begin
            wr_reg(sdi_pkg::ADDR_CONF, (32'(m) << 2) | (32'(m & 1) << 1) | 32'h1);
            run_steps(3, 1'b0, m[0], (m % 3) + 1, 1 << m);
            chk_pos();
            run_steps(5, 1'b1, m[0], 1, 1 << m);
            chk_pos();
        end
        wr_reg(sdi_pkg::ADDR_CONF, 32'h0000_0020);
        run_steps(4, 1'b0, 1'b0, 1, 0);
        chk_pos();
        // Standstill and power-down thresholds after one step.
        wr_reg(sdi_pkg::ADDR_CONF, 32'h0000_0021);
        run_steps(1, 1'b0, 1'b0, 1, 256);
        tick(40);
        check("still_early", {31'h0, standstill}, 32'h0000_0000);
        tick(40);
        check("still_late", {31'h0, standstill}, 32'h0000_0001);
        rd_reg(sdi_pkg::ADDR_STATUS, rd_val);
        check("pd_early", {30'h0, rd_val[17:16]}, 32'h0000_0001);
        tick(70);
        rd_reg(sdi_pkg::ADDR_STATUS, rd_val);
        check("pd_late", {30'h0, rd_val[17:16]}, 32'h0000_0003);
        wr_reg(sdi_pkg::ADDR_CONF, 32'h0000_0061);
        run_steps(1, 1'b0, 1'b0, 1, 256);
        check("fast_early", {31'h0, standstill}, 32'h0000_0000);
        tick(25);
        check("fast_late", {31'h0, standstill}, 32'h0000_0001);
        // A hold level one below run current keeps the decay phase short.
        wr_reg(sdi_pkg::ADDR_CUR, 32'h0001_1E1F);
        wr_reg(sdi_pkg::ADDR_CONF, 32'h0000_00A1);
        check("mode_run", {30'h0, coil_mode}, 32'h0000_0000);
        run_steps(1, 1'b0, 1'b0, 1, 256);
        tick(3);
        check("free_run", {31'h0, coil.a != 0 || coil.b != 0}, 32'h0000_0001);
        tick(1400);
        check("free_still", {14'h0, coil.a, coil.b}, 32'h0000_0000);
        check("mode_free", {30'h0, coil_mode}, 32'h0000_0001);
        wr_reg(sdi_pkg::ADDR_CONF, 32'h0000_0121);
        check("mode_brake", {30'h0, coil_mode}, 32'h0000_0002);
        tick(3);
        check("brake_still", {14'h0, coil.a, coil.b}, 32'h0000_0000);
        wr_reg(sdi_pkg::ADDR_CONF, 32'h0000_0021);
        tick(3);
        check("hold_still", {31'h0, coil.a != 0 || coil.b != 0}, 32'h0000_0001);
        do_reset();
        chk_pos();
        tally_and_finish();
    end

    initial begin
        repeat (20000) @(posedge sys_clk);
        error_cnt++;
        $display("Watchdog expired before the sequence ended");
        tally_and_finish();
    end

endmodule : testbench
